// File: hdl/sss_pkg.sv
// constants of the supply switch sequencer: register map, field layout,
// reset values, state encodings and timing counts.
// assumes a 32-bit apb bus and one clock, pclk, at 250 mhz.
package sss_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00; // supply_control_register
	localparam logic [7:0] ADDR_MODE    = 8'h08; // supply_mode_register
	localparam logic [7:0] ADDR_STATUS  = 8'h14; // supply_status_register
	localparam logic [7:0] ADDR_FWUT    = 8'h18; // flash_wakeup_timer

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CR_OFF_BIT = 2;
	localparam int CR_KEY_LSB = 24;
	localparam int CR_KEY_MSB = 31;

	// ----------------------------------------------------------------
	// mode register fields and reset value
	// ----------------------------------------------------------------
	localparam int MR_VSEL_LSB  = 0;
	localparam int MR_VSEL_MSB  = 2;
	localparam int MR_DEEP_BIT  = 8;
	localparam int MR_RAM_BIT   = 9;
	localparam int MR_LOSS_BIT  = 11;
	localparam int MR_RT_BIT    = 12;
	localparam int MR_LCD_LSB   = 13;
	localparam int MR_LCD_MSB   = 14;
	localparam int MR_FLASH_BIT = 19;
	localparam logic [31:0] MR_RESET = 32'h0008_0a00;

	// ----------------------------------------------------------------
	// status register fields and reset value
	// ----------------------------------------------------------------
	localparam int SR_RT_BIT     = 0;
	localparam int SR_LCD_BIT    = 1;
	localparam int SR_BACKUP_BIT = 2;
	localparam int SR_LOSS_BIT   = 3;
	localparam int SR_FLASH_BIT  = 11;
	localparam logic [31:0] SR_RESET = 32'h0000_0800;

	// ----------------------------------------------------------------
	// flash wake-up timer
	// ----------------------------------------------------------------
	localparam int          FWUT_W     = 8;
	localparam logic [7:0]  FWUT_RESET = 8'h5a; // ninety main clocks

	// ----------------------------------------------------------------
	// lcd supply source modes
	// ----------------------------------------------------------------
	localparam logic [1:0] LCD_NONE = 2'h0;
	localparam logic [1:0] LCD_IDLE = 2'h1;
	localparam logic [1:0] LCD_EXT  = 2'h2;
	localparam logic [1:0] LCD_INT  = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PCLK_HZ        = 250_000_000;
	localparam int SLOW_HZ        = 32_768;
	localparam int SLOW_DIV       = PCLK_HZ / SLOW_HZ; // pclk per slow tick
	localparam int LCD_PUMP_SLOW  = 15;  // charge pump settle, slow cycles
	localparam int LOSS_MIN_SLOW  = 2;   // least core reset on loss
	localparam int FLASH_OFF_GAP  = 2;   // ready low to switch open, mclk

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SSS_CORE_ON   = 3'b000,
		SSS_CORE_RST  = 3'b001,
		SSS_CORE_HALT = 3'b010,
		SSS_CORE_OFF  = 3'b011,
		SSS_CORE_WAKE = 3'b100,
		SSS_CORE_LOSS = 3'b101
	} sss_core_e;

	typedef enum logic [1:0] {
		SSS_LCD_IDLE    = 2'b00,
		SSS_LCD_EOF     = 2'b01,
		SSS_LCD_RELEASE = 2'b10,
		SSS_LCD_DROP    = 2'b11
	} sss_lcd_e;

	typedef enum logic [2:0] {
		SSS_FL_IDLE  = 3'b000,
		SSS_FL_CLOSE = 3'b001,
		SSS_FL_WAIT  = 3'b010,
		SSS_FL_DROP  = 3'b011,
		SSS_FL_OPEN  = 3'b100
	} sss_flash_e;

endpackage : sss_pkg

// File: hdl/sss_supply_switch_sequencer.sv
// supply switch sequencer: apb slave, slow tick, and the power switch
// sequences for core regulator, backup ram, clock domain, lcd and flash.
// assumes synchronous inputs on pclk; analog switches respond on their own.
//
// Contract
// - mode field selects regulator output level between low and high voltage
// - mode bit puts the regulator into deep low-leakage mode
// - off command asserts core reset after resync, then regulator off
// - core halted one slow cycle before core supply is removed
// - regulation loss with enable set, outside deep mode, gives a core reset
// - ram retain bit only acts while in backup mode
// - backup ram switch closes whenever core supply is enabled
// - after reset clock domain enable reads 0 and domain unpowered
// - enable rising: switch on after resync, release reset one cycle later
// - enable falling: assert reset after resync, switch off one cycle later
// - writing the same clock domain enable value is ignored
// - after reset lcd mode is 0 and lcd reset held asserted
// - mode 2 from 0/1: external select, release reset one cycle later
// - mode 0 from 2: assert reset, clear external select one cycle later
// - mode 1 from 2/3: wait end of frame, reset, deselect one later
// - mode 3 from 0/1: pump on, release reset fifteen cycles later
// - mode 0 from 3: assert reset, stop pump one cycle later
// - direct lcd mode change between 2 and 3 is ignored
// - flash enable rising: close switch after one clock, ready after timer
// - flash enable falling: ready low after one clock, open two later
`timescale 1ns/1ps

module sss_supply_switch_sequencer #(
	parameter int          SLOW_DIV = sss_pkg::SLOW_DIV,
	parameter logic [7:0]  CR_KEY   = 8'h5c  // arbitrary key value
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// core regulator
	input  wire logic        vr_ok,
	input  wire logic        wake_request,
	output logic [2:0]       regulator_voltage_select,
	output logic             regulator_deep_mode,
	output logic             regulator_standby,
	output logic             core_reset_n,
	output logic             core_halt,
	output logic             backup_ram_switch_on,
	// clock domain
	output logic             clock_domain_switch_on,
	output logic             clock_domain_reset_n,
	// lcd supply
	input  wire logic        lcd_end_of_frame,
	output logic             lcd_ext_on,
	output logic             lcd_int_on,
	output logic             lcd_reset_n,
	// flash supply
	output logic             flash_switch_off,
	output logic             flash_ready_flag
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int CH_OFF = 0;
	localparam int CH_RT  = 1;
	localparam int CH_LCD = 2;

	typedef struct packed {
		logic [12:0]            div_cnt;
		logic [2:0]             vsel;
		logic                   deep;
		logic                   ram_retain;
		logic                   loss_en;
		logic                   rt_en;
		logic [1:0]             lcd_mode;
		logic                   flash_en;
		logic [7:0]             fwut;
		logic [2:0]             req;
		logic [2:0]             sync1;
		logic [2:0]             sync2;
		sss_pkg::sss_core_e     core_st;
		logic [1:0]             core_cnt;
		logic                   loss_seen;
		logic                   rt_sw;
		logic                   rt_rstn;
		logic                   rt_stat;
		logic                   rt_step;
		sss_pkg::sss_lcd_e      lcd_st;
		logic [1:0]             lcd_cur;
		logic [3:0]             lcd_cnt;
		logic                   lcd_ext;
		logic                   lcd_int;
		logic                   lcd_rstn;
		logic                   lcd_reset_status;
		sss_pkg::sss_flash_e    fl_st;
		logic [7:0]             fl_cnt;
		logic                   fl_off;
		logic                   fl_rdy;
		logic [31:0]            rdata;
	} sss_state_s;

	sss_state_s st;
	sss_state_s next_st;

	// saturating two-bit increment for slow-cycle counters
	function automatic logic [1:0] sss_inc2(input logic [1:0] v);
		sss_inc2 = (v == 2'h3) ? v : v + 2'h1;
	endfunction

	// true when a bus access of this phase hits the given address
	function automatic logic sss_hit(input logic [7:0] a,
	                                 input logic [7:0] target);
		sss_hit = (a == target);
	endfunction

	// ----------------------------------------------------------------
	// combinational decode
	// ----------------------------------------------------------------
	logic slow_tick;
	logic acc_wr;
	logic setup_rd;
	logic mapped;
	logic [31:0] mode_word;
	logic [31:0] status_word;

	// the slow clock is a tick derived from pclk, so the whole block stays
	// in one domain; the divider is a parameter so a bench can shorten it
	assign slow_tick = (st.div_cnt == 13'(SLOW_DIV - 1));
	assign acc_wr    = psel & penable & pwrite;
	assign setup_rd  = psel & ~penable & ~pwrite;
	assign mapped    = sss_hit(paddr, sss_pkg::ADDR_CONTROL)
	                 | sss_hit(paddr, sss_pkg::ADDR_MODE)
	                 | sss_hit(paddr, sss_pkg::ADDR_STATUS)
	                 | sss_hit(paddr, sss_pkg::ADDR_FWUT);

	// read images of the mode and status registers
	always_comb begin
		mode_word = '0;
		mode_word[sss_pkg::MR_VSEL_MSB:sss_pkg::MR_VSEL_LSB] = st.vsel;
		mode_word[sss_pkg::MR_DEEP_BIT]  = st.deep;
		mode_word[sss_pkg::MR_RAM_BIT]   = st.ram_retain;
		mode_word[sss_pkg::MR_LOSS_BIT]  = st.loss_en;
		mode_word[sss_pkg::MR_RT_BIT]    = st.rt_en;
		mode_word[sss_pkg::MR_LCD_MSB:sss_pkg::MR_LCD_LSB] = st.lcd_mode;
		mode_word[sss_pkg::MR_FLASH_BIT] = st.flash_en;
		status_word = '0;
		status_word[sss_pkg::SR_RT_BIT]     = st.rt_stat;
		status_word[sss_pkg::SR_LCD_BIT]    = st.lcd_reset_status;
		status_word[sss_pkg::SR_BACKUP_BIT] =
			(st.core_st == sss_pkg::SSS_CORE_OFF);
		status_word[sss_pkg::SR_LOSS_BIT]   = st.loss_seen;
		status_word[sss_pkg::SR_FLASH_BIT]  = st.fl_rdy;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] wmode;
		logic       lcd_bad;
		logic [2:0] start;
		wmode   = pwdata[sss_pkg::MR_LCD_MSB:sss_pkg::MR_LCD_LSB];
		lcd_bad = 1'b0;
		start   = '0;
		next_st = st;

		// slow tick divider
		next_st.div_cnt = slow_tick ? '0 : st.div_cnt + 13'h1;

		// read data is captured in the setup phase, so it is stable from
		// a flop throughout the access phase
		if (setup_rd) begin
			if (sss_hit(paddr, sss_pkg::ADDR_MODE))
				next_st.rdata = mode_word;
			else if (sss_hit(paddr, sss_pkg::ADDR_STATUS))
				next_st.rdata = status_word;
			else if (sss_hit(paddr, sss_pkg::ADDR_FWUT))
				next_st.rdata = {24'h0, st.fwut};
			else
				next_st.rdata = '0;
		end

		// resync stages step on the slow tick; the first stage feeds only
		// the second
		if (slow_tick) begin
			next_st.sync1 = st.req;
			next_st.sync2 = st.sync1;
			start         = st.sync2;
			next_st.req   = st.req & ~st.sync2;
			next_st.sync1 = st.req & ~st.sync2;
			next_st.sync2 = st.sync1 & ~st.sync2;
		end

		// control register: off command needs the key
		if (acc_wr && sss_hit(paddr, sss_pkg::ADDR_CONTROL)
		    && pwdata[sss_pkg::CR_KEY_MSB:sss_pkg::CR_KEY_LSB] == CR_KEY
		    && pwdata[sss_pkg::CR_OFF_BIT]
		    && st.core_st == sss_pkg::SSS_CORE_ON) begin
			next_st.req[CH_OFF] = 1'b1;
		end

		// mode register write
		if (acc_wr && sss_hit(paddr, sss_pkg::ADDR_MODE)) begin
			next_st.vsel = pwdata[sss_pkg::MR_VSEL_MSB:
			                      sss_pkg::MR_VSEL_LSB];
			next_st.deep       = pwdata[sss_pkg::MR_DEEP_BIT];
			next_st.ram_retain = pwdata[sss_pkg::MR_RAM_BIT];
			next_st.loss_en    = pwdata[sss_pkg::MR_LOSS_BIT];
			// same value written again starts nothing
			if (pwdata[sss_pkg::MR_RT_BIT] != st.rt_en) begin
				next_st.rt_en      = pwdata[sss_pkg::MR_RT_BIT];
				next_st.req[CH_RT] = 1'b1;
			end
			// direct swap between the two sources is dropped
			lcd_bad = (wmode == sss_pkg::LCD_EXT
			           && st.lcd_mode == sss_pkg::LCD_INT)
			        | (wmode == sss_pkg::LCD_INT
			           && st.lcd_mode == sss_pkg::LCD_EXT);
			if (!lcd_bad && wmode != st.lcd_mode) begin
				next_st.lcd_mode    = wmode;
				next_st.req[CH_LCD] = 1'b1;
			end
			// flash runs on the main clock, so no resync stage
			if (pwdata[sss_pkg::MR_FLASH_BIT] != st.flash_en) begin
				next_st.flash_en = pwdata[sss_pkg::MR_FLASH_BIT];
				next_st.fl_st    = pwdata[sss_pkg::MR_FLASH_BIT]
				                 ? sss_pkg::SSS_FL_CLOSE
				                 : sss_pkg::SSS_FL_DROP;
			end
		end
		if (acc_wr && sss_hit(paddr, sss_pkg::ADDR_FWUT))
			next_st.fwut = pwdata[sss_pkg::FWUT_W-1:0];

		// ------------------------------------------------------------
		// core regulator sequence, stepped on slow ticks
		// ------------------------------------------------------------
		if (slow_tick) begin
			case (st.core_st)
			sss_pkg::SSS_CORE_ON: begin
				if (start[CH_OFF]) begin
					next_st.core_st = sss_pkg::SSS_CORE_RST;
				end else if (st.loss_en && !st.deep && !vr_ok) begin
					// loss only counts with the regulator in normal mode
					next_st.core_st   = sss_pkg::SSS_CORE_LOSS;
					next_st.core_cnt  = '0;
					next_st.loss_seen = 1'b1;
				end
			end
			sss_pkg::SSS_CORE_RST:
				next_st.core_st = sss_pkg::SSS_CORE_HALT;
			sss_pkg::SSS_CORE_HALT:
				next_st.core_st = sss_pkg::SSS_CORE_OFF;
			sss_pkg::SSS_CORE_OFF: begin
				if (wake_request) begin
					next_st.core_st  = sss_pkg::SSS_CORE_WAKE;
					next_st.core_cnt = '0;
				end
			end
			sss_pkg::SSS_CORE_WAKE: begin
				// vr_ok must hold one full slow cycle before release
				if (!vr_ok)
					next_st.core_cnt = '0;
				else if (st.core_cnt != 2'h0)
					next_st.core_st = sss_pkg::SSS_CORE_ON;
				else
					next_st.core_cnt = sss_inc2(st.core_cnt);
			end
			sss_pkg::SSS_CORE_LOSS: begin
				next_st.core_cnt = sss_inc2(st.core_cnt);
				if (vr_ok && 32'(sss_inc2(st.core_cnt)) >=
				    sss_pkg::LOSS_MIN_SLOW)
					next_st.core_st = sss_pkg::SSS_CORE_ON;
			end
			default:
				next_st.core_st = sss_pkg::SSS_CORE_ON;
			endcase
		end

		// ------------------------------------------------------------
		// clock domain power sequence
		// ------------------------------------------------------------
		if (slow_tick) begin
			if (st.rt_step) begin
				// second step one slow cycle after the first
				next_st.rt_step = 1'b0;
				if (st.rt_en) begin
					next_st.rt_rstn = 1'b1;
					next_st.rt_stat = 1'b1;
				end else begin
					next_st.rt_sw   = 1'b0;
					next_st.rt_stat = 1'b0;
				end
			end else if (start[CH_RT]) begin
				next_st.rt_step = 1'b1;
				if (st.rt_en)
					next_st.rt_sw = 1'b1;
				else
					next_st.rt_rstn = 1'b0;
			end
		end

		// ------------------------------------------------------------
		// lcd supply source sequence
		// ------------------------------------------------------------
		if (slow_tick) begin
			case (st.lcd_st)
			sss_pkg::SSS_LCD_IDLE: begin
				if (start[CH_LCD]) begin
					next_st.lcd_cur = st.lcd_mode;
					if (st.lcd_mode == sss_pkg::LCD_EXT) begin
						next_st.lcd_ext = 1'b1;
						next_st.lcd_cnt = 4'h1;
						next_st.lcd_st  = sss_pkg::SSS_LCD_RELEASE;
					end else if (st.lcd_mode == sss_pkg::LCD_INT) begin
						next_st.lcd_int = 1'b1;
						next_st.lcd_cnt = 4'(sss_pkg::LCD_PUMP_SLOW);
						next_st.lcd_st  = sss_pkg::SSS_LCD_RELEASE;
					end else if (st.lcd_cur == sss_pkg::LCD_EXT
					             || st.lcd_cur == sss_pkg::LCD_INT) begin
						if (st.lcd_mode == sss_pkg::LCD_IDLE) begin
							next_st.lcd_st = sss_pkg::SSS_LCD_EOF;
						end else begin
							next_st.lcd_rstn = 1'b0;
							next_st.lcd_st   = sss_pkg::SSS_LCD_DROP;
						end
					end
				end
			end
			sss_pkg::SSS_LCD_EOF: begin
				// wait for the controller to finish its frame
				if (lcd_end_of_frame) begin
					next_st.lcd_rstn = 1'b0;
					next_st.lcd_st   = sss_pkg::SSS_LCD_DROP;
				end
			end
			sss_pkg::SSS_LCD_RELEASE: begin
				if (st.lcd_cnt == 4'h1) begin
					next_st.lcd_rstn = 1'b1;
					next_st.lcd_reset_status     = 1'b1;
					next_st.lcd_st   = sss_pkg::SSS_LCD_IDLE;
				end
				next_st.lcd_cnt = st.lcd_cnt - 4'h1;
			end
			sss_pkg::SSS_LCD_DROP: begin
				next_st.lcd_ext = 1'b0;
				next_st.lcd_int = 1'b0;
				next_st.lcd_reset_status    = 1'b0;
				next_st.lcd_st  = sss_pkg::SSS_LCD_IDLE;
			end
			default:
				next_st.lcd_st = sss_pkg::SSS_LCD_IDLE;
			endcase
		end

		// ------------------------------------------------------------
		// flash power sequence on the main clock
		// ------------------------------------------------------------
		case (st.fl_st)
		sss_pkg::SSS_FL_IDLE: ;
		sss_pkg::SSS_FL_CLOSE: begin
			// the timer value sets the wait before ready
			next_st.fl_off = 1'b0;
			next_st.fl_cnt = st.fwut;
			next_st.fl_st  = sss_pkg::SSS_FL_WAIT;
		end
		sss_pkg::SSS_FL_WAIT: begin
			if (st.fl_cnt <= 8'h1) begin
				next_st.fl_rdy = 1'b1;
				next_st.fl_st  = sss_pkg::SSS_FL_IDLE;
			end
			next_st.fl_cnt = st.fl_cnt - 8'h1;
		end
		sss_pkg::SSS_FL_DROP: begin
			next_st.fl_rdy = 1'b0;
			next_st.fl_cnt = 8'(sss_pkg::FLASH_OFF_GAP);
			next_st.fl_st  = sss_pkg::SSS_FL_OPEN;
		end
		sss_pkg::SSS_FL_OPEN: begin
			if (st.fl_cnt == 8'h1) begin
				next_st.fl_off = 1'b1;
				next_st.fl_st  = sss_pkg::SSS_FL_IDLE;
			end
			next_st.fl_cnt = st.fl_cnt - 8'h1;
		end
		default:
			next_st.fl_st = sss_pkg::SSS_FL_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset puts the clock domain and lcd off, flash powered and ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st            <= '0;
			st.deep       <= sss_pkg::MR_RESET[sss_pkg::MR_DEEP_BIT];
			st.ram_retain <= sss_pkg::MR_RESET[sss_pkg::MR_RAM_BIT];
			st.loss_en    <= sss_pkg::MR_RESET[sss_pkg::MR_LOSS_BIT];
			st.rt_en      <= sss_pkg::MR_RESET[sss_pkg::MR_RT_BIT];
			st.lcd_mode   <= sss_pkg::LCD_NONE;
			st.lcd_cur    <= sss_pkg::LCD_NONE;
			st.flash_en   <= sss_pkg::MR_RESET[sss_pkg::MR_FLASH_BIT];
			st.fwut       <= sss_pkg::FWUT_RESET;
			st.core_st    <= sss_pkg::SSS_CORE_ON;
			st.lcd_st     <= sss_pkg::SSS_LCD_IDLE;
			st.fl_st      <= sss_pkg::SSS_FL_IDLE;
			st.fl_rdy     <= sss_pkg::SR_RESET[sss_pkg::SR_FLASH_BIT];
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// zero wait state slave; unmapped addresses and reads of the
	// write-only control register answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (~mapped
	               | (~pwrite & sss_hit(paddr, sss_pkg::ADDR_CONTROL)));
	assign prdata  = st.rdata;

	assign regulator_voltage_select = st.vsel;
	assign regulator_deep_mode      = st.deep;
	assign regulator_standby = (st.core_st == sss_pkg::SSS_CORE_OFF);
	assign core_reset_n      = (st.core_st == sss_pkg::SSS_CORE_ON);
	assign core_halt = (st.core_st == sss_pkg::SSS_CORE_HALT)
	                 | (st.core_st == sss_pkg::SSS_CORE_OFF);
	// ram switch follows the core supply; retain only matters in backup
	assign backup_ram_switch_on = ~regulator_standby
	                            | st.ram_retain;

	assign clock_domain_switch_on = st.rt_sw;
	assign clock_domain_reset_n   = st.rt_rstn;
	assign lcd_ext_on             = st.lcd_ext;
	assign lcd_int_on             = st.lcd_int;
	assign lcd_reset_n            = st.lcd_rstn;
	assign flash_switch_off       = st.fl_off;
	assign flash_ready_flag       = st.fl_rdy;

endmodule // sss_supply_switch_sequencer

// File: testbench/sss_asserts.sv
// timing checks on the sequencer outputs, bound into the design top.
// assumes SLOW_DIV pclk per slow tick and the flash timer left at reset.
`timescale 1ns/1ps

module sss_asserts #(
	parameter int SLOW_DIV = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// watched outputs
	input wire logic regulator_standby,
	input wire logic core_reset_n,
	input wire logic core_halt,
	input wire logic backup_ram_switch_on,
	input wire logic clock_domain_switch_on,
	input wire logic clock_domain_reset_n,
	input wire logic lcd_ext_on,
	input wire logic lcd_int_on,
	input wire logic lcd_reset_n,
	input wire logic flash_switch_off,
	input wire logic flash_ready_flag
);
	localparam int T = SLOW_DIV;
	localparam int P = 15 * SLOW_DIV;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// halt only ever follows an asserted core reset
	sequence halt_s;
		$rose(core_halt) ##0 !core_reset_n;
	endsequence
	sequence lcd_drop_s;
		$fell(lcd_reset_n) ##0 (lcd_ext_on || lcd_int_on);
	endsequence
	clk_on_a: assert property ($rose(clock_domain_switch_on)
		|-> ##T $rose(clock_domain_reset_n)) else $error("clk on order");
	clk_off_a: assert property ($fell(clock_domain_reset_n)
		|-> ##T $fell(clock_domain_switch_on)) else $error("clk off order");
	lcd_ext_a: assert property ($rose(lcd_ext_on)
		|-> !lcd_reset_n ##T $rose(lcd_reset_n)) else $error("lcd ext");
	lcd_pump_a: assert property ($rose(lcd_int_on)
		|-> ##P $rose(lcd_reset_n)) else $error("lcd pump delay");
	lcd_drop_a: assert property (lcd_drop_s
		|-> ##T !(lcd_ext_on || lcd_int_on)) else $error("lcd drop");
	core_halt_a: assert property (halt_s
		|-> ##T $rose(regulator_standby)) else $error("core off order");
	ram_on_a: assert property (!regulator_standby
		|-> backup_ram_switch_on) else $error("ram switch open");
	flash_off_a: assert property ($fell(flash_ready_flag)
		|-> ##2 $rose(flash_switch_off)) else $error("flash off order");
endmodule // sss_asserts

bind sss_supply_switch_sequencer sss_asserts #(.SLOW_DIV(SLOW_DIV))
	sss_asserts_i (.pclk, .presetn, .regulator_standby, .core_reset_n,
	.core_halt, .backup_ram_switch_on, .clock_domain_switch_on,
	.clock_domain_reset_n, .lcd_ext_on, .lcd_int_on, .lcd_reset_n,
	.flash_switch_off, .flash_ready_flag);

// File: testbench/sss_partner.sv
// regulator and lcd controller model facing the sequencer.
// assumes the bench commands regulation loss and wake-up.
`timescale 1ns/1ps

module sss_partner (
	// clock, reset and bench commands
	input wire logic pclk,
	input wire logic presetn,
	input wire logic drop,
	input wire logic wake,
	// regulator and lcd side
	input wire logic regulator_standby,
	output logic     vr_ok,
	output logic     wake_request,
	output logic     lcd_end_of_frame
);
	logic [2:0] rise;
	logic [4:0] frm;
	// regulator is slow to regulate again after standby ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise <= 3'h7;
			frm  <= 5'h00;
		end else begin
			rise <= regulator_standby ? 3'h0 : rise + 3'(rise != 3'h7);
			frm  <= frm + 5'h01;
		end
	end
	assign vr_ok            = (rise == 3'h7) && !drop;
	assign wake_request     = wake;
	// frame end spans a whole slow tick so it is never missed
	assign lcd_end_of_frame = frm[4:2] == 3'h7;
endmodule // sss_partner

// File: testbench/sss_supply_switch_sequencer_test.sv
// self-checking bench: apb master, scenario tasks and verdict.
// assumes SLOW_DIV of 4 and the sss_partner model.
`timescale 1ns/1ps

module sss_supply_switch_sequencer_test;
	localparam logic [7:0] KEY = 8'h5c; // arbitrary key value
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, mr;
	logic [2:0]  regulator_voltage_select;
	logic        regulator_deep_mode, regulator_standby, core_reset_n;
	logic        core_halt, backup_ram_switch_on, clock_domain_switch_on;
	logic        clock_domain_reset_n, lcd_ext_on, lcd_int_on, lcd_reset_n;
	logic        flash_switch_off, flash_ready_flag, vr_ok, wake_request;
	logic        lcd_end_of_frame, drop, wake, err;
	int          fail_count, cmp_count, cyc;

	sss_supply_switch_sequencer #(.SLOW_DIV(4), .CR_KEY(KEY))
		sss_supply_switch_sequencer_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .vr_ok,
		.wake_request, .regulator_voltage_select, .regulator_deep_mode,
		.regulator_standby, .core_reset_n, .core_halt,
		.backup_ram_switch_on, .clock_domain_switch_on,
		.clock_domain_reset_n, .lcd_end_of_frame, .lcd_ext_on,
		.lcd_int_on, .lcd_reset_n, .flash_switch_off, .flash_ready_flag);
	sss_partner sss_partner_i (.pclk, .presetn, .drop, .wake,
		.regulator_standby, .vr_ok, .wake_request, .lcd_end_of_frame);

	always #2 pclk = ~pclk;
	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task report_and_stop;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask

	task chk1(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask

	// one apb transfer; request held until pready is seen
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task mset(input int b, input logic v);
		mr[b] = v;
		xfer(1'b1, sss_pkg::ADDR_MODE, mr);
		@(posedge pclk);
	endtask

	// poll a status bit; a sequence that never ends shows as a mismatch
	task wait_sr(input int b, input logic v);
		for (int i = 0; i < 200; i++) begin
			xfer(1'b0, sss_pkg::ADDR_STATUS, 32'h0);
			if (rd[b] === v) break;
		end
		chk1("status bit", v, rd[b]);
	endtask

	task t_reset;
		xfer(1'b0, sss_pkg::ADDR_MODE, 32'h0);
		chk("mode", sss_pkg::MR_RESET, rd);
		xfer(1'b0, sss_pkg::ADDR_STATUS, 32'h0);
		chk("status", sss_pkg::SR_RESET, rd);
		chk1("lcd reset", 1'b0, lcd_reset_n);
		chk1("clk switch", 1'b0, clock_domain_switch_on);
		xfer(1'b0, 8'h1c, 32'h0);
		chk1("unmapped", 1'b1, err);
	endtask

	task t_clock;
		mset(sss_pkg::MR_RT_BIT, 1'b1);
		chk1("clk early", 1'b0, clock_domain_switch_on);
		wait_sr(sss_pkg::SR_RT_BIT, 1'b1);
		mset(sss_pkg::MR_RT_BIT, 1'b1);
		repeat (24) @(posedge pclk);
		chk1("clk reset", 1'b1, clock_domain_reset_n);
		mset(sss_pkg::MR_RT_BIT, 1'b0);
		wait_sr(sss_pkg::SR_RT_BIT, 1'b0);
		chk1("clk switch", 1'b0, clock_domain_switch_on);
	endtask

	// pad is assumed fed before external and unfed before pump
	task t_lcd;
		logic [1:0] m [10];
		logic [1:0] cur;
		m = '{2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h0, 2'h3, 2'h1, 2'h2, 2'h1};
		cur = sss_pkg::LCD_NONE;
		for (int i = 0; i < 10; i++) begin
			if (!(m[i][1] && cur[1])) cur = m[i];
			mr[sss_pkg::MR_LCD_MSB -: 2] = m[i];
			xfer(1'b1, sss_pkg::ADDR_MODE, mr);
			wait_sr(sss_pkg::SR_LCD_BIT, cur[1]);
			chk1("lcd ext", cur == sss_pkg::LCD_EXT, lcd_ext_on);
			chk1("lcd pump", cur == sss_pkg::LCD_INT, lcd_int_on);
			mr[sss_pkg::MR_LCD_MSB -: 2] = cur;
			xfer(1'b0, sss_pkg::ADDR_MODE, 32'h0);
			chk("mode", mr, rd);
		end
	endtask

	task t_flash;
		xfer(1'b1, sss_pkg::ADDR_FWUT, 32'h0000_005a);
		mset(sss_pkg::MR_FLASH_BIT, 1'b0);
		wait_sr(sss_pkg::SR_FLASH_BIT, 1'b0);
		chk1("flash open", 1'b1, flash_switch_off);
		mset(sss_pkg::MR_FLASH_BIT, 1'b1);
		wait_sr(sss_pkg::SR_FLASH_BIT, 1'b1);
		chk1("flash ready", 1'b1, flash_ready_flag);
		chk1("flash closed", 1'b0, flash_switch_off);
	endtask

	task t_core;
		mr[2:0] = 3'h5;
		mset(sss_pkg::MR_DEEP_BIT, 1'b1);
		chk("vsel", 32'h5, {29'h0, regulator_voltage_select});
		chk1("deep", 1'b1, regulator_deep_mode);
		mset(sss_pkg::MR_DEEP_BIT, 1'b0);
		drop <= 1'b1;
		repeat (16) @(posedge pclk);
		chk1("loss reset", 1'b0, core_reset_n);
		drop <= 1'b0;
		repeat (24) @(posedge pclk);
		wait_sr(sss_pkg::SR_LOSS_BIT, 1'b1);
		mset(sss_pkg::MR_RAM_BIT, 1'b0);
		chk1("ram early", 1'b1, backup_ram_switch_on);
		xfer(1'b1, sss_pkg::ADDR_CONTROL, {KEY, 24'h000004});
		repeat (40) @(posedge pclk);
		chk1("standby", 1'b1, regulator_standby);
		chk1("halt", 1'b1, core_halt);
		chk1("ram off", 1'b0, backup_ram_switch_on);
		wake <= 1'b1;
		repeat (12) @(posedge pclk);
		wake <= 1'b0;
		repeat (40) @(posedge pclk);
		chk1("ram on", 1'b1, backup_ram_switch_on);
		chk1("core up", 1'b1, core_reset_n);
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, drop, wake} = '0;
		{paddr, pwdata} = '0;
		{fail_count, cmp_count, cyc} = '0;
		mr = sss_pkg::MR_RESET;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_clock();
		t_lcd();
		t_flash();
		t_core();
		report_and_stop();
	end
endmodule // sss_supply_switch_sequencer_test
